// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [15:0] bus_addr = 16'h0;
    logic bus_wr = 1'h0;
    logic bus_bit_wr = 1'h0;
    logic [2:0] bus_bit_idx = 3'h0;
    logic [7:0] bus_wdata = 8'h0;
    logic bus_rd = 1'h0;
    logic companion_timer_out = 1'h0;
    logic low_speed_clk = 1'h0;
    logic [1:0] pin_direction_bit = 2'h0;
    logic [1:0] pin_output_latch = 2'h0;
    wire [7:0] bus_rdata;
    wire [1:0] tout;
    wire [1:0] timer_match_irq;
    wire [1:0] pin_out;
    wire [1:0] pin_oe;
    logic [1:0] tprev = 2'h0;
    logic rst_q = 1'h0;
    int mismatches = 0;
    int check_count = 0;
    int mdl [2] = '{0, 0};
    int d0 [6] = '{1, 2, 4, 64, 1024, 6};
    int d1 [8] = '{1, 4, 16, 64, 4096, 1280, 5120, 10};
    logic [31:0] rs = 32'h44;
    logic [31:0] rp = 32'h44;
    int v;

    tmh_ctrl i_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus_addr(bus_addr),
        .bus_wr(bus_wr),
        .bus_bit_wr(bus_bit_wr),
        .bus_bit_idx(bus_bit_idx),
        .bus_wdata(bus_wdata),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .companion_timer_out(companion_timer_out),
        .low_speed_clk(low_speed_clk),
        .pin_direction_bit(pin_direction_bit),
        .pin_output_latch(pin_output_latch),
        .unit0_timer_out(tout[0]),
        .unit1_timer_out(tout[1]),
        .timer_match_irq(timer_match_irq),
        .timer_pin_out(pin_out),
        .timer_pin_oe(pin_oe)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Core clock, a slow oscillator of unrelated phase and a companion output of six cycles.
    always #2 core_clk = ~core_clk;
    initial begin
        #1.3;
        forever #20 low_speed_clk = ~low_speed_clk;
    end
    always begin
        repeat (3) @(posedge core_clk);
        #1 companion_timer_out = ~companion_timer_out;
    end

    // Random port direction and latch keep the pin path busy throughout.
    // The pin is checked against the values that stood at the edge, before they change.
    always @(posedge core_clk) begin
        #1;
        if (rst_n && rst_q) begin
            chk(pin_oe, 2'(~pin_direction_bit), "pin drive");
            chk(pin_out, pin_output_latch | tprev, "pin level");
        end
        tprev = tout;
        rst_q = rst_n;
        rp = xs(rp);
        pin_direction_bit = rp[1:0];
        pin_output_latch = rp[3:2];
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %0h expected %0h", $time, m, g, e);
        end
    endtask

    // One write; the model mirrors byte and single-bit writes to the mode bytes.
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bw, input int b);
        @(posedge core_clk);
        #1;
        bus_addr = a;
        bus_wdata = d;
        bus_bit_wr = bw;
        bus_bit_idx = b[2:0];
        bus_wr = 1'h1;
        @(posedge core_clk);
        bus_wr <= 1'h0;
        if (a == 16'hff69 || a == 16'hff6c) begin
            if (bw) mdl[a[2]][b] = d[0];
            else mdl[a[2]] = d;
        end
    endtask

    task automatic rd(input logic [15:0] a, input int e);
        @(posedge core_clk);
        #1;
        bus_addr = a;
        bus_rd = 1'h1;
        @(posedge core_clk);
        bus_rd <= 1'h0;
        #1;
        chk(bus_rdata, e[7:0], "read data");
    endtask

    // Stopping first keeps mode changes legal; the second compare is set on every start.
    task automatic start(input int u, input logic [7:0] m, input logic [7:0] c0, input int c1);
        wr(u ? 16'hff6c : 16'hff69, 8'h00, 1'h0, 0);
        wr(u ? 16'hff1a : 16'hff18, c0, 1'h0, 0);
        wr(u ? 16'hff1b : 16'hff19, c1[7:0], 1'h0, 0);
        wr(u ? 16'hff6c : 16'hff69, m, 1'h0, 0);
    endtask

    // Cycles between two requests; optionally the output must have inverted.
    task automatic period(input int u, input int e, input logic tg);
        int n;
        logic o1;
        n = 0;
        o1 = 1'h0;
        while (timer_match_irq[u] !== 1'h1 && n < 3 * e + 60) begin
            @(posedge core_clk);
            #1 n++;
        end
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
            if (n == 2) o1 = tout[u];
        end while (timer_match_irq[u] !== 1'h1 && n < 2 * e + 60);
        chk(n, e, "request period");
        repeat (2) @(posedge core_clk);
        #1;
        if (tg && e > 1) chk(tout[u], 1'(~o1), "output inversion");
    endtask

    task automatic quiet(input int u);
        int hits;
        hits = 0;
        repeat (300) begin
            @(posedge core_clk);
            #1 if (timer_match_irq[u] !== 1'h0) hits++;
        end
        chk(hits, 0, "request while held");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run of about 25000 cycles.
    initial begin
        #300000;
        mismatches++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'h1;
        rd(16'hff69, 0);
        rd(16'hff6c, 0);
        wr(16'hff6a, 8'h5a, 1'h0, 0);
        rd(16'hff6a, 0);
        // Random stopped settings: read back, held output level, no requests.
        for (int i = 0; i < 8; i++) begin
            rs = xs(rs);
            wr(i[0] ? 16'hff6c : 16'hff69, rs[7:0] & 8'h7f, 1'h0, 0);
            rd(i[0] ? 16'hff6c : 16'hff69, mdl[i[0]]);
            repeat (4) @(posedge core_clk);
            #1 chk(tout[i[0]], mdl[i[0]][1], "stopped level");
            chk(timer_match_irq, 2'h0, "stopped request");
        end
        for (int b = 0; b < 8; b++) begin
            rs = xs(rs);
            wr(16'hff6c, rs[7:0], 1'h1, b);
            rd(16'hff6c, mdl[1]);
        end
        // Every count clock code of unit 1 and codes 0 to 5 of unit 0, compare value zero.
        for (int u = 0; u < 2; u++) begin
            for (int c = 0; c < 6 + 2 * u; c++) begin
                start(u, {1'h1, c[2:0], 4'h1}, 8'h00, 0);
                period(u, u ? d1[c] : d0[c], 1'h1);
            end
        end
        rs = xs(rs);
        v = rs[7:0];
        start(0, 8'h81, v[7:0], 0);
        period(0, v + 1, 1'h1);
        // A second compare above 15 keeps the later running rewrite clear of a match.
        v = rs[13:8] | 6'h10;
        start(0, 8'h89, 8'hc8, v);
        period(0, 201, 1'h0);
        start(1, 8'h85, 8'hc8, v);
        period(1, v + 1, 1'h0);
        // A running rewrite of the second compare waits for the old match.
        wr(16'hff1b, 8'(v + 8), 1'h0, 0);
        period(1, v + 9, 1'h0);
        start(1, 8'h8d, 8'h00, 0);
        quiet(1);
        start(0, 8'h85, 8'h00, 0);
        quiet(0);
        start(0, 8'h01, 8'h00, 0);
        quiet(0);
        // A reset in mid-run must clear both mode bytes and park the outputs.
        @(posedge core_clk);
        #1 rst_n = 1'h0;
        mdl = '{0, 0};
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'h1;
        chk(tout, 2'h0, "reset level");
        rd(16'hff69, mdl[0]);
        rd(16'hff6c, mdl[1]);
        print_verdict();
    end
endmodule // testbench

// [dv/tmh_ctrl_sva.sv]
`timescale 1ns/1ps
module tmh_ctrl_sva (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_bit_wr,
    input wire logic [2:0] bus_bit_idx,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [1:0] pin_direction_bit,
    input wire logic [1:0] pin_output_latch,
    input wire logic unit0_timer_out,
    input wire logic unit1_timer_out,
    input wire logic [1:0] timer_match_irq,
    input wire logic [1:0] timer_pin_out,
    input wire logic [1:0] timer_pin_oe
);
    logic [1:0][7:0] sh;
    wire mapped = bus_addr inside {16'hff69, 16'hff6c, 16'hff18, 16'hff19, 16'hff1a, 16'hff1b};

    // Shadow of both mode bytes, so outputs can be tied to what software set.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sh <= '0;
        end else if (bus_wr && (bus_addr == 16'hff69 || bus_addr == 16'hff6c)) begin
            if (bus_bit_wr) begin
                sh[bus_addr[2]][bus_bit_idx] <= bus_wdata[0];
            end else begin
                sh[bus_addr[2]] <= bus_wdata;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_mode_back: assert property (
        bus_rd && bus_addr == 16'hff69 |=> bus_rdata == $past(sh[0]))
        else $error("Mode byte read back wrong.");
    a_unmapped_read: assert property (
        bus_rd && !mapped |=> bus_rdata == 8'h00)
        else $error("Unmapped read not zero.");
    a_rdata_hold: assert property (
        !bus_rd |=> $stable(bus_rdata))
        else $error("Read data moved without a read.");
    a_stop_quiet: assert property (
        ($stable(sh[0]) && !sh[0][7]) [*4] |-> !timer_match_irq[0] && unit0_timer_out == sh[0][1])
        else $error("Stopped unit 0 not quiet.");
    a_out_off_level: assert property (
        (!sh[1][0] && $stable(sh[1][1])) [*3] |-> unit1_timer_out == sh[1][1])
        else $error("Disabled unit 1 output not at level.");
    a_irq0_cause: assert property (
        timer_match_irq[0] |-> $past(sh[0][7]))
        else $error("Unit 0 request while stopped.");
    a_irq1_cause: assert property (
        timer_match_irq[1] |-> $past(sh[1][7]) && $past(sh[1][3:2]) != 2'h3)
        else $error("Unit 1 request while stopped or prohibited.");
    a_pin_oe_dir: assert property (
        $past(rst_n) |-> timer_pin_oe == ~$past(pin_direction_bit))
        else $error("Pin drive enable wrong.");
    a_pin_level: assert property (
        $past(rst_n) && !$past(pin_direction_bit[0]) |->
        timer_pin_out[0] == ($past(pin_output_latch[0]) | $past(unit0_timer_out)))
        else $error("Pin level wrong.");

    c_irq0: cover property (timer_match_irq[0]);
    c_irq1: cover property (timer_match_irq[1]);
    c_bit_write: cover property (bus_wr && bus_bit_wr);
endmodule // tmh_ctrl_sva

bind tmh_ctrl tmh_ctrl_sva i_sva (.*);

// [src/tmh_ctrl.sv]
`timescale 1ns/1ps
`include "tmh_regs.svh"

module tmh_ctrl
    import tmh_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_bit_wr,
    input wire logic [2:0] bus_bit_idx,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic companion_timer_out,
    input wire logic low_speed_clk,
    input wire logic [1:0] pin_direction_bit,
    input wire logic [1:0] pin_output_latch,
    output logic unit0_timer_out,
    output logic unit1_timer_out,
    output logic [1:0] timer_match_irq,
    output logic [1:0] timer_pin_out,
    output logic [1:0] timer_pin_oe
);
    tmh_state_s st;
    tmh_state_s next_st;
    logic [`TMH_PRS_WIDTH-1:0] prs_pulse;
    logic [`TMH_LOW_WIDTH-1:0] low_pulse;
    logic low_edge;
    logic comp_edge;
    logic [1:0] tick;

    // The slow oscillator is sampled through two stages before its edge is used.
    assign low_edge = st.frl_s2 & ~st.frl_s3;
    // Companion clock edge
    // The companion count clock arrives from logic on this clock, so no synchroniser.
    assign comp_edge = companion_timer_out & ~st.comp_prev;

    // Base-clock prescaler runs all the time so the taps stay phase-stable.
    tmh_prescaler #(
        .W(`TMH_PRS_WIDTH)
    ) u_prs (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .step(1'b1),
        .pulse(prs_pulse)
    );

    // Slow-oscillator prescaler counts synchronized oscillator edges.
    tmh_prescaler #(
        .W(`TMH_LOW_WIDTH)
    ) u_low (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .step(low_edge),
        .pulse(low_pulse)
    );

    // Unit 0 clock select
    // Prohibited codes give no tick, so the counter simply holds.
    always_comb begin
        unique case (st.mode[0].cks)
            3'h0: tick[0] = 1'b1;
            3'h1: tick[0] = prs_pulse[`TMH_TAP_DIV2];
            3'h2: tick[0] = prs_pulse[`TMH_TAP_DIV4];
            3'h3: tick[0] = prs_pulse[`TMH_TAP_DIV64];
            3'h4: tick[0] = prs_pulse[`TMH_TAP_DIV1024];
            3'h5: tick[0] = comp_edge;
            default: tick[0] = 1'b0;
        endcase
    end

    always_comb begin
        unique case (st.mode[1].cks)
            3'h0: tick[1] = 1'b1;
            3'h1: tick[1] = prs_pulse[`TMH_TAP_DIV4];
            3'h2: tick[1] = prs_pulse[`TMH_TAP_DIV16];
            3'h3: tick[1] = prs_pulse[`TMH_TAP_DIV64];
            3'h4: tick[1] = prs_pulse[`TMH_TAP_DIV4096];
            3'h5: tick[1] = low_pulse[`TMH_TAP_DIV128];
            3'h6: tick[1] = low_pulse[`TMH_TAP_DIV512];
            3'h7: tick[1] = low_edge;
        endcase
    end

    // Bit and byte writes
    // A bit write merges one bit into the addressed byte.
    function automatic logic [7:0] merge(input logic [7:0] old);
        logic [7:0] v;
        v = old;
        if (bus_bit_wr) begin
            v[bus_bit_idx] = bus_wdata[0];
        end else begin
            v = bus_wdata;
        end
        return v;
    endfunction

    // Next-state logic for both units, the bus and the samplers.
    always_comb begin
        logic wr_mode;
        logic wr_c0;
        logic wr_c1;
        logic m0;
        logic m1;
        logic [15:0] base0;
        logic [15:0] base1;
        logic [15:0] base_mode;
        wr_mode = 1'b0;
        wr_c0 = 1'b0;
        wr_c1 = 1'b0;
        m0 = 1'b0;
        m1 = 1'b0;
        base0 = 16'h0000;
        base1 = 16'h0000;
        base_mode = 16'h0000;
        next_st = st;
        next_st.frl_s1 = low_speed_clk;
        next_st.frl_s2 = st.frl_s1;
        next_st.frl_s3 = st.frl_s2;
        next_st.comp_prev = companion_timer_out;
        next_st.irq = 2'b00;

        // Registered read data; unmapped addresses read as zero.
        if (bus_rd) begin
            unique case (bus_addr)
                `TMH_ADDR_MODE0: next_st.rdata = st.mode[0];
                `TMH_ADDR_MODE1: next_st.rdata = st.mode[1];
                `TMH_ADDR_CMP0_U0: next_st.rdata = st.cmp0[0];
                `TMH_ADDR_CMP1_U0: next_st.rdata = st.cmp1[0];
                `TMH_ADDR_CMP0_U1: next_st.rdata = st.cmp0[1];
                `TMH_ADDR_CMP1_U1: next_st.rdata = st.cmp1[1];
                default: next_st.rdata = 8'h00;
            endcase
        end

        for (int u = 0; u < 2; u++) begin
            base_mode = (u == 0) ? `TMH_ADDR_MODE0 : `TMH_ADDR_MODE1;
            base0 = (u == 0) ? `TMH_ADDR_CMP0_U0 : `TMH_ADDR_CMP0_U1;
            base1 = (u == 0) ? `TMH_ADDR_CMP1_U0 : `TMH_ADDR_CMP1_U1;
            wr_mode = bus_wr && (bus_addr == base_mode);
            // Compare registers take byte writes only.
            wr_c0 = bus_wr && !bus_bit_wr && (bus_addr == base0);
            wr_c1 = bus_wr && !bus_bit_wr && (bus_addr == base1);

            // Software keeps other bits steady while running, so no guard here.
            if (wr_mode) begin
                next_st.mode[u] = merge(st.mode[u]);
            end
            if (wr_c0) begin
                next_st.cmp0[u] = bus_wdata;
            end

            m0 = tick[u] && (st.cnt[u] == st.cmp0[u]);
            m1 = tick[u] && (st.cnt[u] == st.cmp1[u]);

            if (!st.mode[u].run) begin
                if (wr_c1) begin
                    next_st.cmp1[u] = bus_wdata;
                end
                next_st.cmp1_pend[u] = 1'b0;
            end else if (wr_c1 && m1) begin
                next_st.cmp1_pend[u] = 1'b0;
            end else if (wr_c1) begin
                next_st.cmp1_new[u] = bus_wdata;
                next_st.cmp1_pend[u] = 1'b1;
            end else if (m1 && st.cmp1_pend[u]) begin
                next_st.cmp1[u] = st.cmp1_new[u];
                next_st.cmp1_pend[u] = 1'b0;
            end

            // Stopped timer drives its idle level
            if (!st.mode[u].run) begin
                next_st.cnt[u] = 8'h00;
                next_st.flip[u] = 1'b0;
            end else if (tick[u]) begin
                next_st.cnt[u] = st.cnt[u] + 8'h01;
                unique case (st.mode[u].mode)
                    TMH_MODE_INTERVAL: begin
                        if (m0) begin
                            next_st.irq[u] = 1'b1;
                            next_st.flip[u] = ~st.flip[u];
                            next_st.cnt[u] = 8'h00;
                        end
                    end
                    TMH_MODE_PWM: begin
                        if (m0) begin
                            next_st.irq[u] = 1'b1;
                            next_st.flip[u] = ~st.flip[u];
                            next_st.cnt[u] = 8'h00;
                        end else if (m1) begin
                            next_st.flip[u] = ~st.flip[u];
                        end
                    end
                    // Carrier mode on unit 1 only
                    TMH_MODE_CARRIER: begin
                        if (u == 1) begin
                            if (m0) begin
                                next_st.irq[u] = 1'b1;
                                next_st.flip[u] = ~st.flip[u];
                            end
                            if (m1) begin
                                next_st.irq[u] = 1'b1;
                                next_st.cnt[u] = 8'h00;
                            end
                        end else begin
                            next_st.cnt[u] = st.cnt[u];
                        end
                    end
                    // Prohibited mode leaves the output untouched.
                    TMH_MODE_BAD: begin
                        next_st.cnt[u] = st.cnt[u];
                    end
                endcase
            end

            // Disabled output parks at the level bit
            if (st.mode[u].out_en) begin
                next_st.tout[u] = st.mode[u].level ^ st.flip[u];
            end else begin
                next_st.tout[u] = st.mode[u].level;
            end

            // Shared pin resolution
            // The pin drives only in output mode; the latch must be 0 to pass the timer.
            next_st.pin_oe[u] = ~pin_direction_bit[u];
            next_st.pin_out[u] = pin_output_latch[u] | st.tout[u];
        end
    end

    // All state but the two prescaler counts is held in one register of the packed state.
    // Reset clears everything
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus_rdata = st.rdata;
    assign unit0_timer_out = st.tout[0];
    assign unit1_timer_out = st.tout[1];
    assign timer_match_irq = st.irq;
    assign timer_pin_out = st.pin_out;
    assign timer_pin_oe = st.pin_oe;
endmodule // tmh_ctrl

// [src/tmh_pkg.sv]
package tmh_pkg;

    // Operation mode field of a mode register.
    typedef enum logic [1:0] {
        TMH_MODE_INTERVAL = 2'b00,
        TMH_MODE_CARRIER = 2'b01,
        TMH_MODE_PWM = 2'b10,
        TMH_MODE_BAD = 2'b11
    } tmh_mode_e;

    // Layout of a mode register.
    typedef struct packed {
        logic run;
        logic [2:0] cks;
        tmh_mode_e mode;
        logic level;
        logic out_en;
    } tmh_mode_s;

    // Whole state of the control block apart from the prescaler counts.
    typedef struct packed {
        tmh_mode_s [1:0] mode;
        logic [1:0][7:0] cmp0;
        logic [1:0][7:0] cmp1;
        logic [1:0][7:0] cmp1_new;
        logic [1:0] cmp1_pend;
        logic [1:0][7:0] cnt;
        logic [1:0] flip;
        logic [1:0] tout;
        logic [1:0] irq;
        logic [1:0] pin_out;
        logic [1:0] pin_oe;
        logic [7:0] rdata;
        logic frl_s1;
        logic frl_s2;
        logic frl_s3;
        logic comp_prev;
    } tmh_state_s;

endpackage

// [src/tmh_prescaler.sv]
`timescale 1ns/1ps

// Free-running binary divider; each output is a one-cycle enable pulse.
module tmh_prescaler #(
    parameter int W = 12
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic step,
    output logic [W-1:0] pulse
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmh_ps_s;

    tmh_ps_s st;
    tmh_ps_s next_st;
    logic [W-1:0] ones;

    // Advance only when the source clock steps.
    always_comb begin
        next_st = st;
        if (step) begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Tap k fires once every two to the power k+1 steps.
    assign ones[0] = st.cnt[0];
    assign pulse[0] = step & ones[0];
    for (genvar i = 1; i < W; i++) begin : g_tap
        assign ones[i] = ones[i-1] & st.cnt[i];
        assign pulse[i] = step & ones[i];
    end
endmodule // tmh_prescaler

// [src/tmh_regs.svh]
`ifndef TMH_REGS_SVH
`define TMH_REGS_SVH

// Register addresses in the peripheral address space.
`define TMH_ADDR_MODE0 16'hff69
`define TMH_ADDR_MODE1 16'hff6c
`define TMH_ADDR_CMP0_U0 16'hff18
`define TMH_ADDR_CMP1_U0 16'hff19
`define TMH_ADDR_CMP0_U1 16'hff1a
`define TMH_ADDR_CMP1_U1 16'hff1b

// Mode register field positions.
`define TMH_BIT_RUN 7
`define TMH_BIT_CKS_HI 6
`define TMH_BIT_CKS_LO 4
`define TMH_BIT_MODE_HI 3
`define TMH_BIT_MODE_LO 2
`define TMH_BIT_LEVEL 1
`define TMH_BIT_OUTEN 0

// Reset value of every register in the block.
`define TMH_RESET_VALUE 8'h00

// Prescaler widths and taps; tap k divides by two to the power k+1.
`define TMH_PRS_WIDTH 12
`define TMH_LOW_WIDTH 9
`define TMH_TAP_DIV2 0
`define TMH_TAP_DIV4 1
`define TMH_TAP_DIV16 3
`define TMH_TAP_DIV64 5
`define TMH_TAP_DIV1024 9
`define TMH_TAP_DIV4096 11
`define TMH_TAP_DIV128 6
`define TMH_TAP_DIV512 8

`endif
